// ===== design/sfb_bank1.sv
// bank 1 special function registers with the status word
// What this block does
// - status word holds alu flags, reset cause flags and bank select bits
// - status word accepts writes from any instruction like other registers
// - flag-updating instructions block written zero, nibble-carry, carry bits
// - writes to watchdog timeout and powerdown flags are ignored
// - clearing status zeroes upper three bits and sets zero flag
// - subtraction drives carry as inverted borrow, nibble carry likewise
// - common core registers decode identically in both banks
// - pc bits 12:8 load only from 5-bit holding latch, on upper update or on a pcl write
// - any reset forces all port direction bits to ones (inputs)
// - unimplemented locations and bits read zero, writes have no effect
// - power-on/brown-out and other resets take separate reset values
// - low direct bank select picks bank 0 or bank 1, 128 bytes each
// - carry set on carry-out of msb for add or subtract
`timescale 1ns/10ps
`default_nettype none
module sfb_bank1
  import sfb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       por_reset,
  input  wire logic [6:0] dir_addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       clr_instr,
  input  wire logic       flag_upd,
  input  wire logic [2:0] flag_mask,
  input  wire logic       alu_add,
  input  wire logic       alu_sub,
  input  wire logic [7:0] alu_a,
  input  wire logic [7:0] alu_b,
  input  wire logic       pc_upper_load,
  input  wire logic       wdt_timeout_evt,
  input  wire logic       sleep_evt,
  input  wire logic       wdt_clear_evt,
  input  wire logic       rd_en,
  output logic [7:0]      rd_data,
  output logic [7:0]      alu_result,
  output logic [12:0]     pc_value,
  output logic [8:0]      mem_addr,
  output logic            mem_wr,
  output logic [7:0]      mem_wdata,
  input  wire logic [7:0] mem_rdata,
  output logic [7:0]      dir_a,
  output logic [7:0]      dir_b,
  output logic [7:0]      dir_cap,
  output logic [7:0]      option_out,
  output logic [7:0]      intctl_out,
  output logic [7:0]      pie_out,
  output logic [7:0]      t2_period,
  output logic [7:0]      analog_cfg
);
  logic [7:0] status_r;
  logic [7:0] pointer_r;
  logic [7:0] pc_upper_holding_latch_r;
  logic [7:0] pcl_r;
  logic [4:0] pc_hi_r;
  logic [7:0] pwr_r;
  logic [7:0] option_r;
  logic [7:0] intctl_r;
  logic [7:0] pie_r;
  logic [7:0] t2_r;
  logic [7:0] analog_r;
  logic [7:0] dir_a_r;
  logic [7:0] dir_b_r;
  logic [7:0] dir_cap_r;
  logic [7:0] addr_full;
  logic [7:0] addr_eff;
  logic       wr_cmd;
  logic [7:0] wval;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic       f_c;
  logic       f_dc;
  logic       f_z;
  logic [7:0] status_nxt;

  // bank comes from the low select bit only; high bit is ignored
  assign addr_full = {status_r[ST_RP0], dir_addr};
  // common registers fold onto one decode regardless of bank
  always_comb begin
    addr_eff = addr_full;
    case (dir_addr)
      7'h00, 7'h02, 7'h03, 7'h04, 7'h0a, 7'h0b: addr_eff = {1'b1, dir_addr};
      default: addr_eff = addr_full;
    endcase
  end

  // add uses a+b; subtract b-a as two's complement so carry is not-borrow
  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    if (alu_sub) begin
      sum9 = {1'b0, alu_b} + {1'b0, ~alu_a} + 9'h001;
      sum5 = {1'b0, alu_b[3:0]} + {1'b0, ~alu_a[3:0]} + 5'h01;
    end else if (alu_add) begin
      // idle cycles give zero so no stale sum reaches the result port
      sum9 = {1'b0, alu_b} + {1'b0, alu_a};
      sum5 = {1'b0, alu_b[3:0]} + {1'b0, alu_a[3:0]};
    end
  end
  assign res  = clr_instr ? 8'h00 : sum9[7:0];
  assign f_c  = sum9[8];
  assign f_dc = sum5[4];
  assign f_z  = (res == 8'h00);

  assign wr_cmd = wr_en | clr_instr;
  assign wval   = clr_instr ? 8'h00 : wr_data;

  // indirect location passes through to data memory
  assign mem_addr  = {1'b0, pointer_r};
  assign mem_wr    = wr_cmd && addr_eff == ADDR_INDIRECT;
  assign mem_wdata = wval;

  // status next value: flags win over written data
  always_comb begin
    status_nxt = status_r;
    if (wr_cmd && addr_eff == ADDR_STATUS) begin
      status_nxt[ST_IRP] = wval[ST_IRP];
      status_nxt[ST_RP1] = wval[ST_RP1];
      status_nxt[ST_RP0] = wval[ST_RP0];
      // any flag-affecting instruction, clear included, blocks all three
      if (!clr_instr && !flag_upd) begin
        status_nxt[ST_Z]  = wval[ST_Z];
        status_nxt[ST_DC] = wval[ST_DC];
        status_nxt[ST_C]  = wval[ST_C];
      end
    end
    if (clr_instr)
      status_nxt[ST_Z] = 1'b1;
    if (flag_upd) begin
      if (flag_mask[2])
        status_nxt[ST_Z] = f_z;
      if (flag_mask[1])
        status_nxt[ST_DC] = f_dc;
      if (flag_mask[0])
        status_nxt[ST_C] = f_c;
    end
    // device logic alone moves timeout and powerdown
    if (wdt_clear_evt) begin
      status_nxt[ST_TO] = 1'b1;
      status_nxt[ST_PD] = 1'b1;
    end
    if (sleep_evt) begin
      status_nxt[ST_TO] = 1'b1;
      status_nxt[ST_PD] = 1'b0;
    end
    if (wdt_timeout_evt)
      status_nxt[ST_TO] = 1'b0;
  end

  // por gives 0001 1xxx (x as 0); other resets keep flags
  always_ff @(posedge clock) begin
    if (rst && por_reset)
      status_r <= RST_STATUS;
    else if (rst) begin
      status_r[7:5] <= 3'h0;
      status_r[ST_TO] <= ~wdt_timeout_evt;
      status_r[ST_PD] <= status_r[ST_PD];
    end else
      status_r <= status_nxt;
  end

  // pointer, pcl and latch
  always_ff @(posedge clock) begin
    if (rst && por_reset)
      pointer_r <= RST_ZERO;
    else if (!rst && wr_cmd && addr_eff == ADDR_POINTER)
      pointer_r <= wval;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pcl_r    <= RST_ZERO;
      pc_upper_holding_latch_r <= RST_ZERO;
      pc_hi_r  <= 5'h00;
    end else begin
      if (wr_cmd && addr_eff == ADDR_PCL)
        pcl_r <= wval;
      if (wr_cmd && addr_eff == ADDR_PC_UPPER_HOLDING_LATCH)
        pc_upper_holding_latch_r <= wval & MASK_PC_UPPER_HOLDING_LATCH;
      // upper pc never writable directly, only from the latch
      if (pc_upper_load || (wr_cmd && addr_eff == ADDR_PCL))
        pc_hi_r <= pc_upper_holding_latch_r[4:0];
    end
  end
  assign pc_value = {pc_hi_r, pcl_r};

  // direction registers force inputs on every reset
  always_ff @(posedge clock) begin
    if (rst) begin
      dir_a_r   <= RST_DIR & MASK_DIR_A;
      dir_b_r   <= RST_DIR;
      dir_cap_r <= RST_DIR & MASK_DIR_CAP;
    end else if (wr_cmd) begin
      if (addr_eff == ADDR_DIR_A)
        dir_a_r <= wval & MASK_DIR_A;
      if (addr_eff == ADDR_DIR_B)
        dir_b_r <= wval;
      if (addr_eff == ADDR_DIR_CAP)
        dir_cap_r <= wval & MASK_DIR_CAP;
    end
  end

  // control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      option_r <= RST_OPTION;
      pie_r    <= RST_ZERO;
      t2_r     <= RST_T2;
      analog_r <= RST_ZERO;
      intctl_r <= {7'h00, intctl_r[0] & ~por_reset};
    end else if (wr_cmd) begin
      if (addr_eff == ADDR_OPTION)
        option_r <= wval;
      if (addr_eff == ADDR_PIE)
        pie_r <= wval & MASK_PIE;
      if (addr_eff == ADDR_T2_PERIOD)
        t2_r <= wval;
      if (addr_eff == ADDR_ANALOG)
        analog_r <= wval & MASK_ANALOG;
      if (addr_eff == ADDR_INTCTL)
        intctl_r <= wval;
    end
  end

  // power cause bits: por clears them, software may set them
  always_ff @(posedge clock) begin
    if (rst && por_reset)
      pwr_r <= RST_PWR_POR;
    else if (!rst && wr_cmd && addr_eff == ADDR_PWR_CAUSE)
      pwr_r <= wval & MASK_PWR;
  end

  // read mux, zero elsewhere
  always_ff @(posedge clock) begin
    if (rst)
      rd_data <= 8'h00;
    else if (rd_en) begin
      case (addr_eff)
        ADDR_INDIRECT:  rd_data <= mem_rdata;
        ADDR_OPTION:    rd_data <= option_r;
        ADDR_PCL:       rd_data <= pcl_r;
        ADDR_STATUS:    rd_data <= status_r;
        ADDR_POINTER:   rd_data <= pointer_r;
        ADDR_DIR_A:     rd_data <= dir_a_r;
        ADDR_DIR_B:     rd_data <= dir_b_r;
        ADDR_DIR_CAP:   rd_data <= dir_cap_r;
        ADDR_PC_UPPER_HOLDING_LATCH:    rd_data <= pc_upper_holding_latch_r;
        ADDR_INTCTL:    rd_data <= intctl_r;
        ADDR_PIE:       rd_data <= pie_r;
        ADDR_PWR_CAUSE: rd_data <= pwr_r;
        ADDR_T2_PERIOD: rd_data <= t2_r;
        ADDR_ANALOG:    rd_data <= analog_r;
        default:        rd_data <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      alu_result <= 8'h00;
    else
      alu_result <= res;
  end

  assign dir_a      = dir_a_r;
  assign dir_b      = dir_b_r;
  assign dir_cap    = dir_cap_r;
  assign option_out = option_r;
  assign intctl_out = intctl_r;
  assign pie_out    = pie_r;
  assign t2_period  = t2_r;
  assign analog_cfg = analog_r;

  // assertions
  property p_flag_block;
    @(posedge clock) disable iff (rst)
      (flag_upd && flag_mask[0] && !wdt_timeout_evt)
        |=> status_r[ST_C] == $past(f_c);
  endproperty
  a_flag_block: assert property (p_flag_block)
    else $error("carry not from alu");

  property p_to_pd_ro;
    @(posedge clock) disable iff (rst)
      (!wdt_clear_evt && !sleep_evt && !wdt_timeout_evt)
        |=> $stable(status_r[4:3]);
  endproperty
  a_to_pd_ro: assert property (p_to_pd_ro)
    else $error("to/pd changed by write");

  property p_clr_status;
    @(posedge clock) disable iff (rst)
      (clr_instr && addr_eff == ADDR_STATUS && !flag_upd)
        |=> status_r[7:5] == 3'h0 && status_r[ST_Z]
            && status_r[1:0] == $past(status_r[1:0]);
  endproperty
  a_clr_status: assert property (p_clr_status)
    else $error("clear status wrong");

  property p_sub_borrow;
    @(posedge clock) disable iff (rst)
      (alu_sub && !clr_instr) |-> f_c == (alu_b >= alu_a);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("borrow polarity");

  property p_pc_hi;
    @(posedge clock) disable iff (rst)
      pc_upper_load |=> pc_value[12:8] == $past(pc_upper_holding_latch_r[4:0]);
  endproperty
  a_pc_hi: assert property (p_pc_hi)
    else $error("pc upper not from latch");

  property p_dir_reset;
    @(posedge clock) rst |=> dir_b == 8'hff && dir_a == 8'h3f;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("ports not inputs");

  property p_unimpl;
    @(posedge clock) disable iff (rst)
      (rd_en && addr_eff == 8'h88) |=> rd_data == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented nonzero");

  property p_common;
    @(posedge clock) disable iff (rst)
      (wr_en && !clr_instr && dir_addr == 7'h04)
        |=> pointer_r == $past(wr_data);
  endproperty
  a_common: assert property (p_common)
    else $error("pointer not common");

  property p_indirect_wr;
    @(posedge clock) disable iff (rst)
      (wr_en && !clr_instr && dir_addr == 7'h00)
        |-> mem_wr && mem_wdata == wr_data && mem_addr == {1'b0, pointer_r};
  endproperty
  a_indirect_wr: assert property (p_indirect_wr)
    else $error("indirect write lost");

  // pin or watchdog reset must not disturb the powerdown flag
  property p_other_reset;
    @(posedge clock) (rst && !por_reset)
      |=> status_r[7:5] == 3'h0 && status_r[ST_PD] == $past(status_r[ST_PD]);
  endproperty
  a_other_reset: assert property (p_other_reset)
    else $error("other reset status wrong");
endmodule : sfb_bank1
`default_nettype wire

// ===== design/sfb_pkg.sv
// constants for the bank 1 special function register block
package sfb_pkg;
  localparam logic [7:0] ADDR_INDIRECT  = 8'h80;
  localparam logic [7:0] ADDR_OPTION    = 8'h81;
  localparam logic [7:0] ADDR_PCL       = 8'h82;
  localparam logic [7:0] ADDR_STATUS    = 8'h83;
  localparam logic [7:0] ADDR_POINTER   = 8'h84;
  localparam logic [7:0] ADDR_DIR_A     = 8'h85;
  localparam logic [7:0] ADDR_DIR_B     = 8'h86;
  localparam logic [7:0] ADDR_DIR_CAP   = 8'h87;
  localparam logic [7:0] ADDR_PC_UPPER_HOLDING_LATCH    = 8'h8a;
  localparam logic [7:0] ADDR_INTCTL    = 8'h8b;
  localparam logic [7:0] ADDR_PIE       = 8'h8c;
  localparam logic [7:0] ADDR_PWR_CAUSE = 8'h8e;
  localparam logic [7:0] ADDR_T2_PERIOD = 8'h92;
  localparam logic [7:0] ADDR_ANALOG    = 8'h9f;
  localparam logic [6:0] COMMON_MASK    = 7'h7f;
  // status bit positions
  localparam int ST_C    = 0;
  localparam int ST_DC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_PD   = 3;
  localparam int ST_TO   = 4;
  localparam int ST_RP0  = 5;
  localparam int ST_RP1  = 6;
  localparam int ST_IRP  = 7;
  // implemented bit masks
  localparam logic [7:0] MASK_DIR_A   = 8'h3f;
  localparam logic [7:0] MASK_DIR_CAP = 8'h05;
  localparam logic [7:0] MASK_PC_UPPER_HOLDING_LATCH  = 8'h1f;
  localparam logic [7:0] MASK_PIE     = 8'h47;
  localparam logic [7:0] MASK_PWR     = 8'h03;
  localparam logic [7:0] MASK_ANALOG  = 8'h07;
  // reset values
  localparam logic [7:0] RST_OPTION   = 8'hff;
  localparam logic [7:0] RST_DIR      = 8'hff;
  localparam logic [7:0] RST_T2       = 8'hff;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_STATUS   = 8'h18;
  localparam logic [7:0] RST_PWR_POR  = 8'h00;
endpackage : sfb_pkg

// ===== test/tb_sfb_bank1.sv
// self-checking bench for the bank 1 register block
`timescale 1ns/10ps
`default_nettype none
module tb_sfb_bank1;
  import sfb_pkg::*;
  logic        clock, rst, por_reset, wr_en, clr_instr, flag_upd, rd_en;
  logic        alu_add, alu_sub, pc_upper_load, mem_wr;
  logic        wdt_timeout_evt, sleep_evt, wdt_clear_evt;
  logic [6:0]  dir_addr;
  logic [2:0]  flag_mask;
  logic [7:0]  wr_data, alu_a, alu_b, rd_data, alu_result, mem_wdata;
  logic [7:0]  mem_rdata, dir_a, dir_b, dir_cap, option_out, intctl_out;
  logic [7:0]  pie_out, t2_period, analog_cfg, st;
  logic [12:0] pc_value;
  logic [8:0]  mem_addr;
  logic [31:0] seed;
  int          err_count, num_checks;
  logic [6:0]  ta [10] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h0a, 7'h0b, 7'h0c,
                           7'h0e, 7'h12, 7'h1f};
  logic [7:0]  tm [10] = '{8'hff, MASK_DIR_A, 8'hff, MASK_DIR_CAP, MASK_PC_UPPER_HOLDING_LATCH,
                           8'hff, MASK_PIE, MASK_PWR, 8'hff, MASK_ANALOG};
  logic [6:0]  ua [6] = '{7'h08, 7'h09, 7'h0d, 7'h0f, 7'h10, 7'h1e};

  sfb_bank1 u_sfb_bank1 (
    .clock(clock), .rst(rst), .por_reset(por_reset), .dir_addr(dir_addr),
    .wr_en(wr_en), .wr_data(wr_data), .clr_instr(clr_instr),
    .flag_upd(flag_upd), .flag_mask(flag_mask), .alu_add(alu_add),
    .alu_sub(alu_sub), .alu_a(alu_a), .alu_b(alu_b),
    .pc_upper_load(pc_upper_load), .wdt_timeout_evt(wdt_timeout_evt),
    .sleep_evt(sleep_evt), .wdt_clear_evt(wdt_clear_evt), .rd_en(rd_en),
    .rd_data(rd_data), .alu_result(alu_result), .pc_value(pc_value),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .dir_a(dir_a), .dir_b(dir_b), .dir_cap(dir_cap),
    .option_out(option_out), .intctl_out(intctl_out), .pie_out(pie_out),
    .t2_period(t2_period), .analog_cfg(analog_cfg));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    dir_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clock);
    dir_addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    chk(rd_data, e);
  endtask

  // one-cycle event strobes; dir_addr aims clear at the status word
  task automatic pulse(input int k);
    @(negedge clock);
    dir_addr = ADDR_STATUS[6:0];
    case (k)
      0: sleep_evt = 1'b1;
      1: wdt_clear_evt = 1'b1;
      2: wdt_timeout_evt = 1'b1;
      3: pc_upper_load = 1'b1;
      default: clr_instr = 1'b1;
    endcase
    @(negedge clock);
    {sleep_evt, wdt_clear_evt, wdt_timeout_evt, pc_upper_load, clr_instr} = '0;
  endtask

  task automatic do_rst(input logic por, input logic wdt);
    @(negedge clock);
    rst = 1'b1;
    por_reset = por;
    wdt_timeout_evt = wdt;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    wdt_timeout_evt = 1'b0;
  endtask

  // w also writes status, whose flag bits must still follow the alu
  task automatic alu(input logic sub, input logic [7:0] a, b, input logic w);
    logic [8:0] s;
    logic       dc;
    s = sub ? {1'b0, b} - {1'b0, a} : {1'b0, a} + {1'b0, b};
    dc = sub ? (b[3:0] >= a[3:0]) : ((a[3:0] + b[3:0]) > 15);
    @(negedge clock);
    {alu_a, alu_b, alu_add, alu_sub} = {a, b, ~sub, sub};
    {flag_upd, flag_mask, wr_en} = {1'b1, 3'b111, w};
    dir_addr = ADDR_STATUS[6:0];
    wr_data = {st[7:5], 5'h00};
    @(negedge clock);
    {alu_add, alu_sub, flag_upd, wr_en} = 4'h0;
    chk(alu_result, s[7:0]);
    st[2:0] = {s[7:0] == 8'h00, dc, sub ? ~s[8] : s[8]};
    rd(ADDR_STATUS[6:0], st);
  endtask

  initial begin
    {rst, por_reset} = 2'b11;
    {wr_en, clr_instr, flag_upd, rd_en, alu_add, alu_sub} = '0;
    {pc_upper_load, wdt_timeout_evt, sleep_evt, wdt_clear_evt} = '0;
    {dir_addr, flag_mask, wr_data, alu_a, alu_b, mem_rdata} = '0;
    {err_count, num_checks} = '0;
    seed = 32'hcc680669;
    st = RST_STATUS;
    do_rst(1'b1, 1'b0);
    chk(dir_a, MASK_DIR_A);
    chk(dir_b, RST_DIR);
    chk(dir_cap, MASK_DIR_CAP);
    chk({option_out, t2_period}, {RST_OPTION, RST_T2});
    chk({pie_out, analog_cfg, intctl_out}, 24'h000000);
    rd(ADDR_STATUS[6:0], RST_STATUS);
    wr(ADDR_STATUS[6:0], 8'h27);
    st = 8'h3f;
    rd(ADDR_STATUS[6:0], st);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      wr(ta[i], seed[7:0]);
      rd(ta[i], seed[7:0] & tm[i]);
    end
    // reserved capture direction bits left clear on purpose
    wr(ADDR_DIR_CAP[6:0], MASK_DIR_CAP);
    rd(ADDR_DIR_CAP[6:0], MASK_DIR_CAP);
    foreach (ua[i]) begin
      wr(ua[i], 8'hff);
      rd(ua[i], 8'h00);
    end
    wr(ADDR_PC_UPPER_HOLDING_LATCH[6:0], 8'h15);
    wr(ADDR_STATUS[6:0], 8'h07);
    rd(ADDR_PC_UPPER_HOLDING_LATCH[6:0], 8'h15);
    wr(ADDR_STATUS[6:0], 8'h27);
    wr(ADDR_PC_UPPER_HOLDING_LATCH[6:0], 8'hea);
    wr(ADDR_PCL[6:0], 8'h5a);
    chk(pc_value, 13'h0a5a);
    wr(ADDR_PC_UPPER_HOLDING_LATCH[6:0], 8'h03);
    chk(pc_value, 13'h0a5a);
    pulse(3);
    chk(pc_value, 13'h035a);
    wr(ADDR_POINTER[6:0], 8'h33);
    chk(mem_addr, 9'h033);
    @(negedge clock);
    {dir_addr, wr_data, wr_en} = {ADDR_INDIRECT[6:0], 8'h5c, 1'b1};
    #1 chk({mem_wr, mem_wdata}, 9'h15c);
    @(negedge clock);
    wr_en = 1'b0;
    mem_rdata = 8'ha5;
    rd(ADDR_INDIRECT[6:0], 8'ha5);
    alu(1'b1, 8'h01, 8'h01, 1'b1);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      alu(seed[8], seed[7:0], seed[23:16], seed[9]);
    end
    pulse(0);
    st[4:3] = 2'b10;
    rd(ADDR_STATUS[6:0], st);
    pulse(1);
    st[4:3] = 2'b11;
    rd(ADDR_STATUS[6:0], st);
    pulse(2);
    st[4] = 1'b0;
    rd(ADDR_STATUS[6:0], st);
    pulse(4);
    st = (st & 8'h1b) | 8'h04;
    rd(ADDR_STATUS[6:0], st);
    // pin reset keeps the flags; timeout during reset leaves TO low
    do_rst(1'b0, 1'b1);
    st = st & 8'h0f;
    rd(ADDR_STATUS[6:0], st);
    chk({dir_b, dir_a}, {RST_DIR, MASK_DIR_A});
    do_rst(1'b0, 1'b0);
    st = (st & 8'h0f) | 8'h10;
    rd(ADDR_STATUS[6:0], st);
    rd(ADDR_PC_UPPER_HOLDING_LATCH[6:0], 8'h00);
    give_verdict;
  end

  initial begin
    #1000000;
    err_count++;
    give_verdict;
  end
endmodule // tb_sfb_bank1
`default_nettype wire
